// file: design/asq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic serialIn,
  output logic [2:0] convChannel,
  output logic [1:0] convRange,
  output logic convStart,
  output logic refPowered,
  output logic corePowered,
  output logic [1:0] powerMode,
  output logic [1:0] seqMode
);
  // ---------------------------------------------------------------------------
  // link domain: frame shifter on falling serial-clock edges
  // ---------------------------------------------------------------------------
  logic [4:0] bitCount;                // falling edges counted in this frame
  logic [15:0] shiftReg;               // bits received so far
  logic [7:0] maskLink;                // channel inclusion mask
  logic [7:0] rangeLowLink;            // range codes channels 0..3
  logic [7:0] rangeHighLink;           // range codes channels 4..7
  logic [11:0] ctrlLink;               // control payload
  logic frameToggle;                   // flips at each completed frame
  logic ctrlToggle;                    // flips at each control load
  logic maskToggle;                    // flips at each mask load
  logic [15:0] next_shift;             // shifter including current bit
  logic linkClear;                     // count clear: deselected or in reset

  // reset clears the count too, so the first frame never starts from an unknown count
  assign linkClear = selectN | ~rstn;

  // next shifter value with the bit on this edge
  always_comb begin
    next_shift = {shiftReg[14:0], serialIn};
  end

  // edge counter, cleared while frame select is high or under reset
  always_ff @(negedge serialClock or posedge linkClear) begin
    if (linkClear) begin
      bitCount <= 5'h00;
    end else if (bitCount != 5'(asq_pkg::FRAME_BITS)) begin
      bitCount <= bitCount + 5'h01;
    end
  end

  // data sampled on falling edges
  always_ff @(negedge serialClock or negedge rstn) begin
    if (!rstn) begin
      shiftReg <= 16'h0000;
    end else begin
      shiftReg <= next_shift;
    end
  end

  // mask and range registers load on the eleventh edge
  always_ff @(negedge serialClock or negedge rstn) begin
    if (!rstn) begin
      maskLink <= asq_pkg::MASK_RESET;
      rangeLowLink <= asq_pkg::RANGE_RESET;
      rangeHighLink <= asq_pkg::RANGE_RESET;
      maskToggle <= 1'b0;
    end else if (!selectN && bitCount == 5'(asq_pkg::SHORT_LOAD_EDGE - 1)
                 && next_shift[10]) begin
      case (next_shift[9:8])
        asq_pkg::SEL_RANGE_LOW: begin
          rangeLowLink <= next_shift[7:0];
        end
        asq_pkg::SEL_RANGE_HIGH: begin
          rangeHighLink <= next_shift[7:0];
        end
        asq_pkg::SEL_MASK: begin
          maskLink <= next_shift[7:0];
          maskToggle <= ~maskToggle;
        end
        default: begin
          maskLink <= maskLink;              // control loads later
        end
      endcase
    end
  end

  // control register loads on the fifteenth edge
  always_ff @(negedge serialClock or negedge rstn) begin
    if (!rstn) begin
      ctrlLink <= asq_pkg::CTRL_RESET;
      ctrlToggle <= 1'b0;
    end else if (!selectN && bitCount == 5'(asq_pkg::CTRL_LOAD_EDGE - 1)
                 && next_shift[14] && next_shift[13:12] == asq_pkg::SEL_CTRL) begin
      // fifteen bits in: header sits at 14..12, payload (frame bits 12..1) at 11..0
      ctrlLink <= next_shift[11:0];
      ctrlToggle <= ~ctrlToggle;
    end
  end

  // frame completion event on the sixteenth edge
  always_ff @(negedge serialClock or negedge rstn) begin
    if (!rstn) begin
      frameToggle <= 1'b0;
    end else if (!selectN && bitCount == 5'(asq_pkg::FRAME_BITS - 1)) begin
      frameToggle <= ~frameToggle;
    end
  end

  // ---------------------------------------------------------------------------
  // crossing into the system clock
  // ---------------------------------------------------------------------------
  logic [2:0] frameSync;               // toggle synchroniser plus history
  logic [2:0] ctrlSync;
  logic [2:0] maskSync;
  logic frameDone;                     // one-cycle conversion end
  logic ctrlNew;                       // control settled after load
  logic maskNew;                       // mask settled after load
  logic ctrlPending;                   // control waits for conversion end
  logic [7:0] maskReg;                 // mask copy, stable after toggle
  logic [7:0] rangeLow;
  logic [7:0] rangeHigh;
  logic [11:0] ctrlReg;

  // toggles pass two flops before any compare
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frameSync <= 3'h0;
      ctrlSync <= 3'h0;
      maskSync <= 3'h0;
    end else begin
      frameSync <= {frameSync[1:0], frameToggle};
      ctrlSync <= {ctrlSync[1:0], ctrlToggle};
      maskSync <= {maskSync[1:0], maskToggle};
    end
  end

  assign frameDone = frameSync[2] ^ frameSync[1];
  assign ctrlNew = ctrlSync[2] ^ ctrlSync[1];
  assign maskNew = maskSync[2] ^ maskSync[1];

  // capture link words once their event has crossed; words are stable then
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      maskReg <= asq_pkg::MASK_RESET;
      rangeLow <= asq_pkg::RANGE_RESET;
      rangeHigh <= asq_pkg::RANGE_RESET;
    end else begin
      // mask taken as soon as it settles, so a list restart at frame end sees it
      if (frameDone || maskNew) begin
        maskReg <= maskLink;
      end
      // ranges only move at a frame end
      if (frameDone) begin
        rangeLow <= rangeLowLink;
        rangeHigh <= rangeHighLink;
      end
    end
  end

  // control held aside until the conversion carrying it ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlPending <= 1'b0;
    end else if (ctrlNew) begin
      ctrlPending <= 1'b1;                   // set wins over clear
    end else if (frameDone) begin
      ctrlPending <= 1'b0;
    end
  end

  // control takes effect at the end of that conversion
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= asq_pkg::CTRL_RESET;
    end else if (frameDone && (ctrlPending || ctrlNew)) begin
      ctrlReg <= ctrlLink;
    end
  end

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  // range code for one channel from the two range registers
  function automatic logic [1:0] rangeOf(input logic [2:0] ch, input logic [7:0] lo,
                                         input logic [7:0] hi);
    logic [7:0] r;
    r = ch[2] ? hi : lo;
    case (ch[1:0])
      2'h0: rangeOf = r[7:6];
      2'h1: rangeOf = r[5:4];
      2'h2: rangeOf = r[3:2];
      default: rangeOf = r[1:0];
    endcase
  endfunction

  // lowest flagged channel at or above a start (msb of mask is channel 0)
  function automatic logic [3:0] nextInMask(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h8;                                // none found
    for (int i = 7; i >= 0; i--) begin
      if (m[7 - i] && 4'(i) >= from) begin
        res = 4'(i);
      end
    end
    nextInMask = res;
  endfunction

  // control payload holds frame bits 12..1, so frame position p sits at p - 1
  // channel address field of a control word
  function automatic logic [2:0] ctrlAddr(input logic [11:0] c);
    ctrlAddr = c[asq_pkg::CTRL_ADDR_POS - 1 +: 3];
  endfunction

  // sequencer select field of a control word
  function automatic logic [1:0] ctrlSeq(input logic [11:0] c);
    ctrlSeq = c[asq_pkg::CTRL_SEQ_POS - 1 +: 2];
  endfunction

  // ---------------------------------------------------------------------------
  // channel sequencer
  // ---------------------------------------------------------------------------
  logic [2:0] chanPtr;                 // channel of the next conversion
  logic seqRun;                        // list or consecutive sequence active
  logic [2:0] addrField;
  logic [1:0] seqField;
  logic [1:0] pwrField;
  logic [3:0] nextFlag;
  logic [3:0] firstFlag;

  assign addrField = ctrlAddr(ctrlReg);
  assign seqField = ctrlSeq(ctrlReg);
  assign pwrField = ctrlReg[asq_pkg::CTRL_PWR_POS - 1 +: 2];  // frame bits 7..6
  assign nextFlag = nextInMask(maskReg, {1'b0, chanPtr} + 4'h1);
  assign firstFlag = nextInMask(maskReg, 4'h0);

  // pointer steps at each conversion end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chanPtr <= 3'h0;
      seqRun <= 1'b0;
    end else if (frameDone && (ctrlPending || ctrlNew)) begin
      // fresh control: list and consecutive modes start over at their first channel, other modes at the address
      case (asq_pkg::asq_seq_e'(ctrlSeq(ctrlLink)))
        asq_pkg::ASQ_SEQ_LIST: begin
          // lowest flagged channel first; an empty mask leaves the list idle
          chanPtr <= firstFlag[2:0];
          seqRun <= !firstFlag[3];
        end
        asq_pkg::ASQ_SEQ_CONSEC: begin
          chanPtr <= 3'h0;
          seqRun <= 1'b1;
        end
        default: begin
          chanPtr <= ctrlAddr(ctrlLink);
          seqRun <= 1'b0;
        end
      endcase
    end else if (maskNew && seqField == asq_pkg::ASQ_SEQ_LIST) begin
      seqRun <= 1'b0;
      chanPtr <= 3'h0;
    end else if (frameDone) begin
      case (asq_pkg::asq_seq_e'(seqField))
        asq_pkg::ASQ_SEQ_LIST: begin
          if (!seqRun) begin
            chanPtr <= firstFlag[2:0];
            seqRun <= !firstFlag[3];
          end else if (nextFlag[3]) begin
            chanPtr <= firstFlag[2:0];
          end else begin
            chanPtr <= nextFlag[2:0];
          end
        end
        asq_pkg::ASQ_SEQ_CONSEC: begin
          chanPtr <= (chanPtr >= addrField) ? 3'h0 : chanPtr + 3'h1;
        end
        default: begin
          chanPtr <= addrField;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic frameDoneDly;                  // frame end one clock on, pointer settled

  // conversion descriptor registered for the analog core; channel, range and
  // start all move on one edge, one clock after the pointer has stepped,
  // so a mid-frame mask restart never shows on the outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frameDoneDly <= 1'b0;
      convChannel <= 3'h0;
      convRange <= asq_pkg::RANGE_RESET[1:0];
      convStart <= 1'b0;
    end else begin
      frameDoneDly <= frameDone;
      convStart <= frameDoneDly;
      // descriptor only refreshed at a conversion start
      if (frameDoneDly) begin
        convChannel <= chanPtr;
        convRange <= rangeOf(chanPtr, rangeLow, rangeHigh);
      end
    end
  end

  // power state after each conversion
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      corePowered <= 1'b1;
      refPowered <= 1'b1;
      powerMode <= 2'h0;
      seqMode <= 2'h0;
    end else begin
      powerMode <= pwrField;
      seqMode <= seqField;
      // delayed frame end: the control word carrying a new mode is live by then
      case (asq_pkg::asq_pwr_e'(pwrField))
        asq_pkg::ASQ_PWR_FULL_OFF: begin
          corePowered <= 1'b0;
          refPowered <= 1'b0;
        end
        asq_pkg::ASQ_PWR_AUTO_OFF: begin
          // everything drops at the end of each conversion
          if (frameDoneDly) begin
            corePowered <= 1'b0;
            refPowered <= 1'b0;
          end
        end
        asq_pkg::ASQ_PWR_STANDBY: begin
          // core drops at conversion end, reference stays up
          if (frameDoneDly) begin
            corePowered <= 1'b0;
          end
          refPowered <= 1'b1;
        end
        default: begin
          corePowered <= 1'b1;
          refPowered <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: design/asq_pkg.sv
package asq_pkg;
  // ---------------------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------------------
  localparam int FRAME_BITS = 16;          // serial-clock cycles per frame
  localparam int SHORT_LOAD_EDGE = 11;     // falling edge loading mask or range
  localparam int CTRL_LOAD_EDGE = 15;      // falling edge loading control
  localparam int DATA_MSB = 12;            // payload msb index within frame
  localparam int CTRL_ADDR_POS = 10;       // channel address field lsb
  localparam int CTRL_PWR_POS = 6;         // power select field lsb
  localparam int CTRL_SEQ_POS = 2;         // sequencer select field lsb
  // ---------------------------------------------------------------------------
  // register select codes (write flag, select a, select b)
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_RANGE_LOW = 2'h1;
  localparam logic [1:0] SEL_RANGE_HIGH = 2'h2;
  localparam logic [1:0] SEL_MASK = 2'h3;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RANGE_RESET = 8'h00;   // all channels plus/minus 10 V
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ASQ_PWR_NORMAL = 2'h0,
    ASQ_PWR_STANDBY = 2'h1,
    ASQ_PWR_AUTO_OFF = 2'h2,
    ASQ_PWR_FULL_OFF = 2'h3
  } asq_pwr_e;
  typedef enum logic [1:0] {
    ASQ_SEQ_NONE = 2'h0,
    ASQ_SEQ_LIST = 2'h1,
    ASQ_SEQ_CONSEC = 2'h2,
    ASQ_SEQ_NONE2 = 2'h3
  } asq_seq_e;
  typedef enum logic [1:0] {
    ASQ_RNG_PM10 = 2'h0,
    ASQ_RNG_PM5 = 2'h1,
    ASQ_RNG_PM2P5 = 2'h2,
    ASQ_RNG_UNI10 = 2'h3
  } asq_rng_e;
  typedef enum logic [1:0] {
    ASQ_ST_IDLE = 2'h0,
    ASQ_ST_FRAME = 2'h1,
    ASQ_ST_DONE = 2'h3
  } asq_st_e;
endpackage

// file: sim/asq_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic serialIn,
  input wire logic [2:0] convChannel,
  input wire logic [1:0] convRange,
  input wire logic convStart,
  input wire logic refPowered,
  input wire logic corePowered,
  input wire logic [1:0] powerMode,
  input wire logic [1:0] seqMode
);
  // ---------------------------------------------------------------------------
  // conversion outputs and power levels
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // start is a single-cycle pulse
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("conversion start held past one cycle");
  // channel only moves at a conversion start
  a_chan_hold: assert property ($changed(convChannel) |-> convStart)
    else $error("channel changed outside a conversion start");
  // range only moves at a conversion start
  a_range_hold: assert property ($changed(convRange) |-> convStart)
    else $error("range changed outside a conversion start");
  // new modes are followed by the next conversion start
  a_mode_apply: assert property ($changed(seqMode) |-> ##[0:3] convStart)
    else $error("sequencer mode changed without a conversion start");
  // consecutive mode steps up by one or wraps to zero
  a_consec_step: assert property (convStart && seqMode == asq_pkg::ASQ_SEQ_CONSEC &&
    $past(seqMode) == asq_pkg::ASQ_SEQ_CONSEC |->
    convChannel == $past(convChannel) + 3'h1 || convChannel == 3'h0)
    else $error("consecutive channel did not step or wrap");
  // full shutdown drops core and reference
  a_full_off: assert property ((powerMode == asq_pkg::ASQ_PWR_FULL_OFF) [*3] |->
    !corePowered && !refPowered)
    else $error("powered while in full shutdown");
  // normal mode keeps everything up
  a_normal_on: assert property ((powerMode == asq_pkg::ASQ_PWR_NORMAL) [*4] |->
    corePowered && refPowered)
    else $error("powered down while in normal mode");
  // standby keeps the reference up
  a_standby_ref: assert property ((powerMode == asq_pkg::ASQ_PWR_STANDBY) [*4] |->
    refPowered)
    else $error("reference dropped in standby");
endmodule
bind asq_sequencer asq_sequencer_props u_asq_sequencer_props (.clock, .rstn, .serialClock,
  .selectN, .serialIn, .convChannel, .convRange, .convStart, .refPowered, .corePowered,
  .powerMode, .seqMode);
`default_nettype wire

// file: sim/asq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asq_host_model (
  output logic serialClock,
  output logic selectN,
  output logic serialIn
);
  // ---------------------------------------------------------------------------
  // serial frame driver
  // ---------------------------------------------------------------------------
  // link clock idles high, frame deselected
  initial begin
    serialClock = 1'b1;
    selectN = 1'b1;
    serialIn = 1'b0;
  end
  // one 16-bit frame, msb first, header bits lead
  task automatic send(input logic [15:0] w);
    #13 selectN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialIn = w[i];
      #40 serialClock = 1'b0; // device samples here
      #40 serialClock = 1'b1;
    end
    selectN = 1'b1;
    serialIn = ~serialIn; // released line no longer shows last bit
    #80;
  endtask
endmodule
`default_nettype wire

// file: sim/adc_sequencer_range_power_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_range_power_config_tb_top;
  // ---------------------------------------------------------------------------
  // clock, reset, wiring
  // ---------------------------------------------------------------------------
  logic clock = 1'b0;
  logic rstn = 1'b0;
  wire logic serialClock, selectN, serialIn; // host frame lines
  logic [2:0] convChannel;
  logic [1:0] convRange;
  logic convStart, refPowered, corePowered;
  logic [1:0] powerMode, seqMode;
  int num_errors = 0;
  int comparisons = 0;
  logic [1:0] rng [8]; // expected range per channel
  logic [2:0] lst [5] = '{3'h2, 3'h4, 3'h7, 3'h2, 3'h4}; // list order
  logic [1:0] pw [4] = '{2'h3, 2'h2, 2'h0, 2'h0}; // {ref, core} per mode
  always #4 clock = ~clock;
  asq_sequencer u_asq_sequencer (.clock, .rstn, .serialClock, .selectN, .serialIn,
    .convChannel, .convRange, .convStart, .refPowered, .corePowered, .powerMode, .seqMode);
  asq_host_model u_asq_host_model (.serialClock, .selectN, .serialIn);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] ctrl(input logic [2:0] a, input logic [1:0] pm,
                                       input logic [1:0] sq);
    return {3'b100, a, 2'b00, pm, 2'b00, sq, 2'b00};
  endfunction
  function automatic logic [15:0] wr8(input logic [1:0] sel, input logic [7:0] d);
    return {1'b1, sel, d, 5'h00};
  endfunction
  task check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task check_conv(input logic [2:0] ch);
    check({5'h0, convChannel}, {5'h0, ch}, "channel");
    check({6'h0, convRange}, {6'h0, rng[ch]}, "range");
  endtask
  task finish_test;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // frame plus bounded wait for its conversion start
  task frame(input logic [15:0] w);
    int n;
    fork
      u_asq_host_model.send(w);
      begin
        n = 0;
        do begin
          @(posedge clock);
          #1 n++;
        end while (convStart !== 1'b1 && n < 400);
        if (n >= 400) begin
          num_errors++;
          $display("MISMATCH %0t no conversion start", $time);
          finish_test();
        end
      end
    join
  endtask
  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) rng[i] = 2'h0;
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (2) @(posedge clock);
    check_conv(3'h0);
    check({4'h0, powerMode, seqMode}, 8'h00, "modes");
    check({6'h0, refPowered, corePowered}, 8'h03, "power");
    $display("test reset done");
    for (int a = 0; a < 8; a++) begin
      frame(ctrl(a[2:0], 2'h0, {a[0], a[0]}));
      check_conv(a[2:0]);
    end
    $display("test single channel done");
    frame(wr8(asq_pkg::SEL_RANGE_LOW, 8'h1b));
    frame(wr8(asq_pkg::SEL_RANGE_HIGH, 8'he4));
    frame({1'b0, asq_pkg::SEL_RANGE_LOW, 8'hff, 5'h00});
    rng = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
    for (int a = 0; a < 8; a++) begin
      frame(ctrl(a[2:0], 2'h0, 2'h0));
      check_conv(a[2:0]);
    end
    $display("test ranges done");
    frame(wr8(asq_pkg::SEL_MASK, 8'h29));
    for (int i = 0; i < 5; i++) begin
      frame(i == 0 ? ctrl(3'h0, 2'h0, 2'h1) : 16'h0000);
      check_conv(lst[i]);
    end
    frame(ctrl(3'h3, 2'h0, 2'h0));
    check_conv(3'h3);
    frame(wr8(asq_pkg::SEL_RANGE_HIGH, 8'h55));
    for (int i = 4; i < 8; i++) rng[i] = 2'h1;
    frame(ctrl(3'h0, 2'h0, 2'h1));
    check_conv(3'h2);
    frame(16'h0000);
    check_conv(3'h4);
    $display("test list done");
    for (int i = 0; i < 5; i++) begin
      frame(i == 0 ? ctrl(3'h2, 2'h0, 2'h2) : 16'h0000);
      check_conv(3'(i % 3));
    end
    check({6'h0, seqMode}, 8'h02, "sequencer mode");
    $display("test consecutive done");
    for (int i = 3; i >= 0; i--) begin
      frame(ctrl(3'h0, i[1:0], 2'h0));
      repeat (4) @(posedge clock);
      check({6'h0, powerMode}, {6'h0, i[1:0]}, "power mode");
      check({6'h0, refPowered, corePowered}, {6'h0, pw[i]}, "power");
    end
    $display("test power done");
    finish_test();
  end
endmodule
`default_nettype wire
